/* dss_pkg.sv */
// Shared constants and types of the dormant state sequencer
package dss_pkg;

  // Clock period
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Boot head start ahead of the tracking area update timer
  localparam int unsigned TAU_MARGIN_US = 100;
  localparam int unsigned TAU_MARGIN_CYC =
    (TAU_MARGIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default widths
  localparam int unsigned WAKE_N_DEF = 4;
  localparam int unsigned TIMER_W_DEF = 32;

  // Cycles the power-on pin is given to settle after reset
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // Reported power state codes
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_ACTIVE = 2'h1;
  localparam logic [1:0] PWR_DORMANT = 2'h2;

  // Sequencer states, Gray steps along off, boot, attach, active, detach, dormant
  typedef enum logic [2:0] {
    SEQ_OFF = 3'h0,
    SEQ_BOOT = 3'h1,
    SEQ_ATTACH = 3'h3,
    SEQ_ACTIVE = 3'h2,
    SEQ_DETACH = 3'h6,
    SEQ_DORMANT = 3'h7,
    SEQ_TAU = 3'h5
  } dss_seq_type;

endpackage : dss_pkg

/* dss_sequencer.sv */
// Power-state sequencer for the dormant state of a cellular module
`timescale 1ns/1ps
// Overview of operation
// - Standalone mode enters dormant without network help
// - Standalone request detaches if attached, then dormant
// - Standalone wake boots, reattaches, stays active
// - Without timer, standalone dormant lasts indefinitely
// - Power saving wake boots then sends area update
// - After area update, stay active for pending data
// - Inactivity elapsed returns to dormant unrequested
// - Wake configuration kept across power saving cycles
// - Wake configuration writable during active period
// - Context kept; downlink held for next active
// - Power saving wake sends without full reattach
// - Power-up with power-on asserted goes active
// - Power-up with power-on deasserted goes dormant
// - Every dormant exit is a full reboot
// - Power-on assertion edge wakes from dormant
// - Power saving wake timer is area timer minus margin; standalone uses its own count
module dss_sequencer #(
  parameter int unsigned WAKE_N = dss_pkg::WAKE_N_DEF,
  parameter int unsigned TIMER_W = dss_pkg::TIMER_W_DEF,
  parameter int unsigned MARGIN_CYC = dss_pkg::TAU_MARGIN_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Pins from outside
  input wire logic i_power_on_n,
  input wire logic [WAKE_N-1:0] i_wake_src,
  // Application control interface
  input wire logic i_standalone_low_power_mode_req,
  input wire logic i_psm_sel,
  input wire logic i_cfg_we,
  input wire logic [WAKE_N-1:0] i_cfg_wake_mask,
  input wire logic i_standalone_tmr_en,
  input wire logic [TIMER_W-1:0] i_standalone_tmr_cycles,
  input wire logic [TIMER_W-1:0] i_tau_cycles,
  input wire logic [TIMER_W-1:0] i_inact_cycles,
  // Processor and network stack handshakes
  input wire logic i_boot_done,
  input wire logic i_attach_done,
  input wire logic i_detach_done,
  input wire logic i_tau_done,
  input wire logic i_net_attached,
  input wire logic i_psm_granted,
  input wire logic i_net_activity,
  input wire logic i_dl_arrive,
  input wire logic i_dl_drained,
  // Status and requests out
  output logic [1:0] o_pwr_state,
  output logic o_boot_req,
  output logic o_attach_req,
  output logic o_detach_req,
  output logic o_tau_req,
  output logic o_context_kept,
  output logic o_dl_pending,
  output logic [WAKE_N-1:0] o_wake_mask
);

  // Refuse widths the counters and mask cannot serve
  if (WAKE_N < 1 || WAKE_N > 16 || TIMER_W < 8 || TIMER_W > 32 ||
      MARGIN_CYC < 1 || (TIMER_W < 32 && MARGIN_CYC >= (1 << TIMER_W)))
  begin : g_bad_param
    $error("dss_sequencer: unsupported parameter value");
  end

  // Complete state of the sequencer
  typedef struct packed {
    dss_pkg::dss_seq_type seq;     // Current sequencer state
    logic [1:0] settle;            // Power-on pin settling count
    logic pwr_s1;                  // Power-on pin, first stage
    logic pwr_s2;                  // Power-on pin, second stage
    logic pwr_prev;                // Power-on level one cycle ago
    logic [WAKE_N-1:0] wake_s1;    // Wake pins, first stage
    logic [WAKE_N-1:0] wake_s2;    // Wake pins, second stage
    logic [WAKE_N-1:0] wake_mask;  // Armed wake sources
    logic in_psm;                  // Dormant period belongs to PSM
    logic psm_wake;                // Boot follows a PSM dormant period
    logic standalone_wake;         // Boot follows a standalone period
    logic tmr_on;                  // Dormant wake timer armed
    logic [TIMER_W-1:0] tmr;       // Dormant wake timer count
    logic [TIMER_W-1:0] inact;     // Active-period inactivity count
    logic dl_pending;              // Downlink held for delivery
    logic [1:0] pwr_state;         // Reported power state
    logic boot_req;                // Processors booting
    logic attach_req;              // Full reattach requested
    logic detach_req;              // Detach requested
    logic tau_req;                 // Area update requested
  } dss_state_type;

  dss_state_type st_reg;
  dss_state_type st_next;

  // Decoded events, combinational
  logic pwr_edge;
  logic wake_hit;
  logic tmr_expire;
  logic psm_run;
  logic inact_done;
  logic [TIMER_W-1:0] tau_wake;

  // Event decode from settled pin copies
  always_comb
  begin
    // Off-to-on of the active-low power-on pin
    pwr_edge = st_reg.pwr_prev & ~st_reg.pwr_s2;
    wake_hit = |(st_reg.wake_s2 & st_reg.wake_mask);
    // No armed timer means no time-based exit
    tmr_expire = st_reg.tmr_on && (st_reg.tmr <= TIMER_W'(1));
    psm_run = i_psm_sel & i_psm_granted;
    inact_done = (st_reg.inact >= i_inact_cycles);
    // Timer set short of the area timer so boot finishes first
    if (i_tau_cycles > TIMER_W'(MARGIN_CYC))
    begin
      tau_wake = i_tau_cycles - TIMER_W'(MARGIN_CYC);
    end
    else
    begin
      tau_wake = TIMER_W'(1);
    end
  end

  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    // Two-stage capture of the pins
    st_next.pwr_s1 = i_power_on_n;
    st_next.pwr_s2 = st_reg.pwr_s1;
    st_next.pwr_prev = st_reg.pwr_s2;
    st_next.wake_s1 = i_wake_src;
    st_next.wake_s2 = st_reg.wake_s1;
    case (st_reg.seq)
      // Power applied: let the pin settle, then pick the path
      dss_pkg::SEQ_OFF:
      begin
        if (st_reg.settle != dss_pkg::SETTLE_DONE)
        begin
          st_next.settle = st_reg.settle + 2'h1;
        end
        else if (st_reg.pwr_s2)
        begin
          st_next.seq = dss_pkg::SEQ_DORMANT;
        end
        else
        begin
          st_next.seq = dss_pkg::SEQ_BOOT;
        end
      end
      // Boot in progress; entry requests are not looked at here
      dss_pkg::SEQ_BOOT:
      begin
        if (i_boot_done)
        begin
          if (st_reg.psm_wake)
          begin
            st_next.seq = dss_pkg::SEQ_TAU;
          end
          else if (st_reg.standalone_wake)
          begin
            st_next.seq = dss_pkg::SEQ_ATTACH;
          end
          else
          begin
            st_next.seq = dss_pkg::SEQ_ACTIVE;
          end
        end
      end
      // Standalone wake: network reattach
      dss_pkg::SEQ_ATTACH:
      begin
        if (i_attach_done)
        begin
          st_next.seq = dss_pkg::SEQ_ACTIVE;
        end
      end
      // PSM wake: area update, then an active window
      dss_pkg::SEQ_TAU:
      begin
        if (i_tau_done)
        begin
          st_next.seq = dss_pkg::SEQ_ACTIVE;
          st_next.inact = '0;
        end
      end
      // Active: configuration, inactivity, standalone requests
      dss_pkg::SEQ_ACTIVE:
      begin
        if (i_cfg_we)
        begin
          st_next.wake_mask = i_cfg_wake_mask;
        end
        if (psm_run)
        begin
          // Traffic restarts the inactivity window
          if (i_net_activity)
          begin
            st_next.inact = '0;
          end
          else if (inact_done)
          begin
            st_next.seq = dss_pkg::SEQ_DORMANT;
            st_next.in_psm = 1'b1;
          end
          else
          begin
            st_next.inact = st_reg.inact + TIMER_W'(1);
          end
        end
        else if (i_standalone_low_power_mode_req)
        begin
          st_next.in_psm = 1'b0;
          if (i_net_attached)
          begin
            st_next.seq = dss_pkg::SEQ_DETACH;
          end
          else
          begin
            st_next.seq = dss_pkg::SEQ_DORMANT;
          end
        end
      end
      // Waiting for the stack to leave the network
      dss_pkg::SEQ_DETACH:
      begin
        if (i_detach_done)
        begin
          st_next.seq = dss_pkg::SEQ_DORMANT;
        end
      end
      // Dormant: any wake is a full reboot
      dss_pkg::SEQ_DORMANT:
      begin
        if (wake_hit || pwr_edge || tmr_expire)
        begin
          st_next.seq = dss_pkg::SEQ_BOOT;
          st_next.psm_wake = st_reg.in_psm;
          st_next.standalone_wake = ~st_reg.in_psm;
          st_next.tmr_on = 1'b0;
        end
        else if (st_reg.tmr_on)
        begin
          st_next.tmr = st_reg.tmr - TIMER_W'(1);
        end
      end
      default:
      begin
        st_next.seq = dss_pkg::SEQ_OFF;
      end
    endcase
    // Arm the wake timer on dormant entry for PSM or with the standalone timer enabled
    if (st_next.seq == dss_pkg::SEQ_DORMANT &&
        st_reg.seq != dss_pkg::SEQ_DORMANT)
    begin
      st_next.tmr_on = st_next.in_psm | i_standalone_tmr_en;
      st_next.tmr = st_next.in_psm ? tau_wake : i_standalone_tmr_cycles;
    end
    // Downlink held while dormant; arrival wins over drain
    st_next.dl_pending = (st_reg.dl_pending &
      ~(i_dl_drained && st_reg.seq == dss_pkg::SEQ_ACTIVE)) |
      (i_dl_arrive && st_reg.seq == dss_pkg::SEQ_DORMANT);
    // Registered outputs decoded from the next state
    case (st_next.seq)
      dss_pkg::SEQ_OFF: st_next.pwr_state = dss_pkg::PWR_OFF;
      dss_pkg::SEQ_DORMANT: st_next.pwr_state = dss_pkg::PWR_DORMANT;
      default: st_next.pwr_state = dss_pkg::PWR_ACTIVE;
    endcase
    st_next.boot_req = (st_next.seq == dss_pkg::SEQ_BOOT);
    st_next.attach_req = (st_next.seq == dss_pkg::SEQ_ATTACH);
    st_next.detach_req = (st_next.seq == dss_pkg::SEQ_DETACH);
    st_next.tau_req = (st_next.seq == dss_pkg::SEQ_TAU);
  end

  // State register; the wake mask is never reset by a cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_pwr_state = st_reg.pwr_state;
  assign o_boot_req = st_reg.boot_req;
  assign o_attach_req = st_reg.attach_req;
  assign o_detach_req = st_reg.detach_req;
  assign o_tau_req = st_reg.tau_req;
  assign o_context_kept = st_reg.in_psm;
  assign o_dl_pending = st_reg.dl_pending;
  assign o_wake_mask = st_reg.wake_mask;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_dormant_wake;
    st_reg.seq == dss_pkg::SEQ_DORMANT && (wake_hit || pwr_edge);
  endsequence
  // Last boot cycle after a power saving dormant period
  sequence s_psm_boot_end;
    o_boot_req && st_reg.psm_wake && i_boot_done;
  endsequence

  boot_ignores_entry_a: assert property (
    o_boot_req && i_standalone_low_power_mode_req |=> !o_detach_req &&
      o_pwr_state != dss_pkg::PWR_DORMANT)
    else $error("entry taken during boot");
  lp_detach_a: assert property (
    st_reg.seq == dss_pkg::SEQ_ACTIVE && !psm_run &&
      i_standalone_low_power_mode_req && i_net_attached |=>
      o_detach_req ##0 !o_context_kept)
    else $error("standalone entry did not detach");
  lp_direct_a: assert property (
    st_reg.seq == dss_pkg::SEQ_ACTIVE && !psm_run &&
      i_standalone_low_power_mode_req && !i_net_attached |=>
      o_pwr_state == dss_pkg::PWR_DORMANT)
    else $error("standalone entry not direct");
  wake_reboot_a: assert property (
    s_dormant_wake |=> o_boot_req && o_pwr_state == dss_pkg::PWR_ACTIVE)
    else $error("dormant exit without boot");
  psm_tau_a: assert property (
    s_psm_boot_end |=> o_tau_req && !o_attach_req)
    else $error("psm wake did not send area update");
  lp_attach_a: assert property (
    o_boot_req && st_reg.standalone_wake && i_boot_done |=> o_attach_req)
    else $error("standalone wake did not reattach");
  inact_return_a: assert property (
    st_reg.seq == dss_pkg::SEQ_ACTIVE && psm_run && !i_net_activity &&
      inact_done |=> o_pwr_state == dss_pkg::PWR_DORMANT && o_context_kept)
    else $error("inactivity did not return to dormant");
  mask_hold_a: assert property (
    !(i_cfg_we && st_reg.seq == dss_pkg::SEQ_ACTIVE) |=>
      $stable(o_wake_mask))
    else $error("wake mask changed without write");
  mask_write_a: assert property (
    i_cfg_we && st_reg.seq == dss_pkg::SEQ_ACTIVE |=>
      o_wake_mask == $past(i_cfg_wake_mask))
    else $error("active wake mask write lost");
  dl_hold_a: assert property (
    st_reg.seq == dss_pkg::SEQ_DORMANT && i_dl_arrive |=> o_dl_pending)
    else $error("dormant downlink not held");
  tau_timer_a: assert property (
    st_reg.seq == dss_pkg::SEQ_ACTIVE && st_next.seq ==
      dss_pkg::SEQ_DORMANT && st_next.in_psm &&
      i_tau_cycles > TIMER_W'(MARGIN_CYC) |=>
      st_reg.tmr == $past(i_tau_cycles) - TIMER_W'(MARGIN_CYC) &&
      st_reg.tmr_on)
    else $error("psm wake timer not derived");
  pwrup_path_a: assert property (
    st_reg.seq == dss_pkg::SEQ_OFF && st_reg.settle ==
      dss_pkg::SETTLE_DONE |=> (o_boot_req != $past(st_reg.pwr_s2)))
    else $error("power-up path wrong");

endmodule : dss_sequencer

/* dss_net_model.sv */
// Behavioural processors and network stack facing the sequencer
`timescale 1ns/1ps
module dss_net_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Answer delay in cycles
  input wire logic [3:0] i_dly,
  // Requests: boot, attach, detach, area update
  input wire logic [3:0] i_req,
  // Completions, one bit per request
  output logic [3:0] o_done,
  output logic o_net_attached
);
  // Cycles each standing request has waited
  logic [3:0] wait_cnt [4];

  // Answer each standing request once after the delay
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_done <= 4'h0;
      o_net_attached <= 1'b0;
      for (int k = 0; k < 4; k++)
        wait_cnt[k] <= 4'h0;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        // One-cycle completion once the delay has run out
        o_done[k] <= i_req[k] && !o_done[k] && (wait_cnt[k] >= i_dly);
        if (!i_req[k] || o_done[k])
          wait_cnt[k] <= 4'h0;
        else if (wait_cnt[k] < i_dly)
          wait_cnt[k] <= wait_cnt[k] + 4'h1;
      end
      // Attach joins, detach leaves, area update keeps it
      if (o_done[1])
        o_net_attached <= 1'b1;
      else if (o_done[2])
        o_net_attached <= 1'b0;
    end
  end
endmodule : dss_net_model

/* dormant_state_sequencer_test.sv */
// Self-checking bench of the dormant state sequencer
`timescale 1ns/1ps
module dormant_state_sequencer_test;
  localparam int MARGIN = 4;
  // Clock, reset and pins
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_on_n = 1'b0;
  logic [3:0] wake_src = 4'h0;
  // Application controls
  logic lp_req = 1'b0;
  logic psm_sel = 1'b0;
  logic psm_granted = 1'b0;
  logic cfg_we = 1'b0;
  logic [3:0] cfg_mask = 4'h0;
  logic tmr_en = 1'b0;
  logic [31:0] tmr_cyc = 32'h0;
  logic [31:0] tau_cyc = 32'h28;
  logic [31:0] inact_cyc = 32'h8;
  logic net_act = 1'b0;
  logic dl_arrive = 1'b0;
  logic dl_drained = 1'b0;
  logic [3:0] dly = 4'h2;
  // Design outputs; req is boot, attach, detach, area update
  logic [1:0] pwr_state;
  logic [3:0] req;
  logic [3:0] done;
  logic attached;
  logic ctx_kept;
  logic dl_pend;
  logic [3:0] wake_mask;
  // Bookkeeping
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  integer seed = 32'hcbe0;
  logic [3:0] seen = 4'h0;
  logic [3:0] mask;

  // Free-running clock
  always #5 ref_clk = ~ref_clk;

  dss_sequencer #(.WAKE_N(4), .TIMER_W(32), .MARGIN_CYC(MARGIN)) i_dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_power_on_n(power_on_n),
    .i_wake_src(wake_src), .i_standalone_low_power_mode_req(lp_req),
    .i_psm_sel(psm_sel), .i_cfg_we(cfg_we), .i_cfg_wake_mask(cfg_mask),
    .i_standalone_tmr_en(tmr_en), .i_standalone_tmr_cycles(tmr_cyc),
    .i_tau_cycles(tau_cyc),
    .i_inact_cycles(inact_cyc), .i_boot_done(done[0]),
    .i_attach_done(done[1]), .i_detach_done(done[2]),
    .i_tau_done(done[3]), .i_net_attached(attached),
    .i_psm_granted(psm_granted), .i_net_activity(net_act),
    .i_dl_arrive(dl_arrive), .i_dl_drained(dl_drained),
    .o_pwr_state(pwr_state), .o_boot_req(req[0]), .o_attach_req(req[1]),
    .o_detach_req(req[2]), .o_tau_req(req[3]), .o_context_kept(ctx_kept),
    .o_dl_pending(dl_pend), .o_wake_mask(wake_mask));

  dss_net_model i_net (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_dly(dly),
    .i_req(req), .o_done(done), .o_net_attached(attached));

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Compare one value with its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Advance clocks, log requests, guard state code and time
  task automatic step(input int k);
    repeat (k)
    begin
      @(posedge ref_clk);
      seen = seen | req;
      cycles++;
      chk(pwr_state === 2'h3, 1'b0);
      if (cycles > 20000)
      begin
        err_count++;
        complete_run();
      end
    end
  endtask : step

  // Wait bounded for a power state, n keeps the cycles taken
  task automatic wait_pwr(input logic [1:0] s, input int lim);
    n = 0;
    while (pwr_state !== s && n < lim)
    begin
      step(1);
      n++;
    end
  endtask : wait_pwr

  // Wait bounded for masked request bits to read a value
  task automatic wait_req(input logic [3:0] m, input logic [3:0] v);
    n = 0;
    while ((req & m) !== v && n < 80)
    begin
      step(1);
      n++;
    end
    chk(req & m, v);
  endtask : wait_req

  // One-cycle pulse of the standalone request
  task automatic pulse_lp();
    lp_req <= 1'b1;
    step(1);
    lp_req <= 1'b0;
  endtask : pulse_lp

  // Reset for sixteen cycles with a given pin level
  task automatic do_reset(input logic pin);
    rst_n <= 1'b0;
    power_on_n <= pin;
    step(16);
    rst_n <= 1'b1;
    seen = 4'h0;
  endtask : do_reset

  // Main sequence
  initial
  begin
    do_reset(1'b0);
    wait_pwr(dss_pkg::PWR_ACTIVE, 20);
    wait_req(4'hf, 4'h0);
    chk(seen[0], 1'b1);
    chk(pwr_state, dss_pkg::PWR_ACTIVE);
    power_on_n <= 1'b1;
    // Wake sources first, bit 3 left unmasked
    mask = 4'($random(seed));
    mask = {1'b0, mask[2:1], 1'b1};
    cfg_we <= 1'b1;
    cfg_mask <= mask;
    step(1);
    cfg_we <= 1'b0;
    step(2);
    chk(wake_mask, mask);
    // Standalone entry while detached goes straight to dormant
    seen = 4'h0;
    pulse_lp();
    wait_pwr(dss_pkg::PWR_DORMANT, 20);
    chk(pwr_state, dss_pkg::PWR_DORMANT);
    chk(seen[2], 1'b0);
    // Writes, requests and unmasked pins in dormant change nothing
    cfg_we <= 1'b1;
    cfg_mask <= 4'h0;
    lp_req <= 1'b1;
    step(1);
    cfg_we <= 1'b0;
    lp_req <= 1'b0;
    wake_src <= 4'h8;
    step(60);
    chk(pwr_state, dss_pkg::PWR_DORMANT);
    chk(wake_mask, mask);
    // Masked pin wakes; an entry request during boot is dropped
    seen = 4'h0;
    dly <= 4'($random(seed));
    wake_src <= 4'h1;
    wait_req(4'h1, 4'h1);
    pulse_lp();
    wake_src <= 4'h0;
    wait_req(4'hf, 4'h0);
    chk(seen[1:0], 2'h3);
    step(10);
    chk(pwr_state, dss_pkg::PWR_ACTIVE);
    // Attached entry detaches first; wake timer brings it back
    tmr_en <= 1'b1;
    tmr_cyc <= 32'h14;
    // Power saving chosen but not granted: standalone fallback
    psm_sel <= 1'b1;
    seen = 4'h0;
    pulse_lp();
    wait_pwr(dss_pkg::PWR_DORMANT, 60);
    chk(seen[2], 1'b1);
    chk(pwr_state, dss_pkg::PWR_DORMANT);
    wait_req(4'h1, 4'h1);
    wait_req(4'hf, 4'h0);
    tmr_en <= 1'b0;
    // Power saving cycle: inactivity ends in dormant, context kept
    psm_sel <= 1'b1;
    psm_granted <= 1'b1;
    net_act <= 1'b1;
    step(2);
    net_act <= 1'b0;
    seen = 4'h0;
    wait_pwr(dss_pkg::PWR_DORMANT, 30);
    chk(n >= 8 && n <= 11, 1'b1);
    chk(seen[2], 1'b0);
    chk(ctx_kept, 1'b1);
    dl_arrive <= 1'b1;
    step(1);
    dl_arrive <= 1'b0;
    step(2);
    chk(dl_pend, 1'b1);
    // Wake timer runs short of the area timer
    wait_req(4'h1, 4'h1);
    chk(n + 4 >= 40 - MARGIN && n < 40, 1'b1);
    wait_req(4'hf, 4'h0);
    chk(seen[3], 1'b1);
    chk(seen[1], 1'b0);
    chk(dl_pend, 1'b1);
    chk(wake_mask, mask);
    // Activity keeps it up; drained data clears; then back down
    net_act <= 1'b1;
    dl_drained <= 1'b1;
    step(20);
    dl_drained <= 1'b0;
    chk(pwr_state, dss_pkg::PWR_ACTIVE);
    chk(dl_pend, 1'b0);
    net_act <= 1'b0;
    wait_pwr(dss_pkg::PWR_DORMANT, 15);
    chk(pwr_state, dss_pkg::PWR_DORMANT);
    // Power-up with pin released lands in dormant; pin wakes it
    psm_sel <= 1'b0;
    do_reset(1'b1);
    wait_pwr(dss_pkg::PWR_DORMANT, 10);
    chk(pwr_state, dss_pkg::PWR_DORMANT);
    chk(seen[0], 1'b0);
    power_on_n <= 1'b0;
    wait_req(4'h1, 4'h1);
    wait_req(4'hf, 4'h0);
    chk(pwr_state, dss_pkg::PWR_ACTIVE);
    complete_run();
  end
endmodule : dormant_state_sequencer_test
